// ---- fpsc_core_model.sv ----
// file: processor-side model issuing arithmetic completions and rounding requests
`timescale 1ns/1ps
module fpsc_core_model
(
  input  wire logic       ref_clk_i,
  output logic            op_done_o,
  output logic [5:0]      op_cond_o,
  output logic            rnd_req_o,
  output logic            rnd_fixed_o,
  output logic [1:0]      rnd_fixed_mode_o,
  output logic [3:0]      rnd_bits_o
);
  initial
  begin
    op_done_o        = 1'b0;
    op_cond_o        = 6'h00;
    rnd_req_o        = 1'b0;
    rnd_fixed_o      = 1'b0;
    rnd_fixed_mode_o = 2'h0;
    rnd_bits_o       = 4'h0;
  end

  // one completed operation; conditions not held once released
  task automatic do_op(input logic [5:0] c);
    @(posedge ref_clk_i);
    op_done_o <= 1'b1;
    op_cond_o <= c;
    @(posedge ref_clk_i);
    op_done_o <= 1'b0;
    op_cond_o <= ~c;
  endtask : do_op

  // one rounding request, bits are sign, lsb, guard, sticky
  task automatic do_round(input logic f, input logic [1:0] fm, input logic [3:0] b);
    @(posedge ref_clk_i);
    rnd_req_o        <= 1'b1;
    rnd_fixed_o      <= f;
    rnd_fixed_mode_o <= fm;
    rnd_bits_o       <= b;
    @(posedge ref_clk_i);
    rnd_req_o  <= 1'b0;
    rnd_bits_o <= ~b;
  endtask : do_round
endmodule : fpsc_core_model

// ---- fpsc_pkg.sv ----
// package: field layout, view addresses and rounding encodings of the fp control/status bank
package fpsc_pkg;

  // control-register move address width and view addresses
  localparam int unsigned          FPSC_ADDR_W          = 5;
  localparam logic [4:0]           FPSC_ADDR_CC_VIEW    = 5'h19;
  localparam logic [4:0]           FPSC_ADDR_EXC_VIEW   = 5'h1A;
  localparam logic [4:0]           FPSC_ADDR_CTL_STATUS = 5'h1F;

  // field widths
  localparam int unsigned          FPSC_DATA_W   = 32;
  localparam int unsigned          FPSC_CC_W     = 8;
  localparam int unsigned          FPSC_COND_W   = 5;
  localparam int unsigned          FPSC_CAUSE_W  = 6;

  // field positions in the main control/status register
  localparam int unsigned          FPSC_CS_CC_HI_MSB = 31;
  localparam int unsigned          FPSC_CS_CC_HI_LSB = 25;
  localparam int unsigned          FPSC_CS_FLUSH     = 24;
  localparam int unsigned          FPSC_CS_CC0       = 23;
  localparam int unsigned          FPSC_CAUSE_MSB    = 17;
  localparam int unsigned          FPSC_CAUSE_LSB    = 12;
  localparam int unsigned          FPSC_ENABLE_MSB   = 11;
  localparam int unsigned          FPSC_ENABLE_LSB   = 7;
  localparam int unsigned          FPSC_FLAG_MSB     = 6;
  localparam int unsigned          FPSC_FLAG_LSB     = 2;
  localparam int unsigned          FPSC_RM_MSB       = 1;
  localparam int unsigned          FPSC_RM_LSB       = 0;

  // condition bit order, inexact lowest
  localparam int unsigned          FPSC_BIT_INEXACT   = 0;
  localparam int unsigned          FPSC_BIT_UNDERFLOW = 1;
  localparam int unsigned          FPSC_BIT_OVERFLOW  = 2;
  localparam int unsigned          FPSC_BIT_DIVZERO   = 3;
  localparam int unsigned          FPSC_BIT_INVALID   = 4;
  localparam int unsigned          FPSC_BIT_UNIMPL    = 5;

  // reset values of the fields that have one
  localparam logic [7:0]           FPSC_CC_RST     = 8'h00;
  localparam logic [5:0]           FPSC_CAUSE_RST  = 6'h00;
  localparam logic [4:0]           FPSC_ENABLE_RST = 5'h00;
  localparam logic                 FPSC_FLUSH_RST  = 1'b0;

  typedef enum logic [1:0]
  {
    fpsc_round_nearest_even    = 2'h0,
    fpsc_round_toward_zero     = 2'h1,
    fpsc_round_toward_plus_inf = 2'h2,
    fpsc_round_toward_minus_inf = 2'h3
  } fpsc_rm_t;

  localparam fpsc_rm_t             FPSC_RM_RST = fpsc_round_nearest_even;

endpackage : fpsc_pkg

// ---- fpsc_round_decide.sv ----
// module: magnitude-increment decision for the four rounding modes
`timescale 1ns/1ps
module fpsc_round_decide
(
  fpsc_round_if.decider rnd
);
  import fpsc_pkg::*;

  always_comb
  begin
    rnd.inexact = rnd.guard | rnd.sticky;
    case (rnd.mode)
      // ties go to the even candidate
      fpsc_round_nearest_even:     rnd.round_up = rnd.guard & (rnd.sticky | rnd.lsb);
      fpsc_round_toward_zero:      rnd.round_up = 1'b0;
      fpsc_round_toward_plus_inf:  rnd.round_up = rnd.inexact & ~rnd.sign;
      fpsc_round_toward_minus_inf: rnd.round_up = rnd.inexact & rnd.sign;
      default:                     rnd.round_up = 1'b0;
    endcase
  end

endmodule : fpsc_round_decide

// ---- fpsc_round_if.sv ----
// interface: rounding request from the register bank to the rounding decider
`timescale 1ns/1ps
interface fpsc_round_if;
  import fpsc_pkg::*;
  fpsc_rm_t mode;
  logic     sign;
  logic     lsb;
  logic     guard;
  logic     sticky;
  logic     round_up;
  logic     inexact;

  modport decider
  (
    input  mode,
    input  sign,
    input  lsb,
    input  guard,
    input  sticky,
    output round_up,
    output inexact
  );

  modport owner
  (
    output mode,
    output sign,
    output lsb,
    output guard,
    output sticky,
    input  round_up,
    input  inexact
  );
endinterface : fpsc_round_if

// ---- fpsc_status_control_regs.sv ----
// module: fp control/status register bank with condition-code and exception views
//
// Function
// - raise exception when an enable bit and its cause bit are both set
// - unimplemented-operation cause has no enable and always raises exception
// - untrapped arithmetic condition sets its flag bits, others unchanged
// - arithmetic operation that raises an exception leaves flags untouched
// - hardware never clears flags, not even at reset; software clears them
// - rounding field selects rounding unless operation fixes its own mode
// - mode 0 rounds to nearest, ties to even
// - mode 1 rounds toward zero
// - mode 2 rounds toward plus infinity
// - mode 3 rounds toward minus infinity
// - all views share one storage; writes visible through every view
// - cause, enable, flag hold one bit per condition; cause adds unimplemented
// - condition-code view shows all eight codes in bits 7:0, read/write
// - reserved bits of both views read as zero
// - exception view holds cause at 17:12 and flags at 6:2
// - each arithmetic operation rewrites every cause bit
`timescale 1ns/1ps
module fpsc_status_control_regs
(
  input  wire logic                          ref_clk_i,
  input  wire logic                          reset_n_i,
  // control-register moves
  input  wire logic                          ctl_wr_i,
  input  wire logic                          ctl_rd_i,
  input  wire logic [fpsc_pkg::FPSC_ADDR_W-1:0] ctl_addr_i,
  input  wire logic [fpsc_pkg::FPSC_DATA_W-1:0] ctl_wdata_i,
  output logic      [fpsc_pkg::FPSC_DATA_W-1:0] ctl_rdata_o,
  output logic                               ctl_rvalid_o,
  // arithmetic completion
  input  wire logic                          op_done_i,
  input  wire logic [fpsc_pkg::FPSC_CAUSE_W-1:0] op_cond_i,
  // rounding request
  input  wire logic                          rnd_req_i,
  input  wire logic                          rnd_fixed_i,
  input  wire logic [1:0]                    rnd_fixed_mode_i,
  input  wire logic                          rnd_sign_i,
  input  wire logic                          rnd_lsb_i,
  input  wire logic                          rnd_guard_i,
  input  wire logic                          rnd_sticky_i,
  output logic                               rnd_incr_o,
  output logic                               rnd_inexact_o,
  output logic                               rnd_valid_o,
  // state seen by the datapath
  output logic [1:0]                         rounding_select_o,
  output logic                               flush_zero_o,
  output logic [fpsc_pkg::FPSC_CC_W-1:0]     fp_condition_codes_o,
  output logic                               fp_trap_o
);
  import fpsc_pkg::*;

  // ----------------------------------------
  // shared field storage
  // ----------------------------------------
  logic [FPSC_CC_W-1:0]    fp_condition_codes;
  logic                    flush_zero;
  logic [FPSC_CAUSE_W-1:0] cause;
  logic [FPSC_COND_W-1:0]  enables;
  logic [FPSC_COND_W-1:0]  flags;
  fpsc_rm_t                rounding_select;

  logic [FPSC_CC_W-1:0]    next_fp_condition_codes;
  logic                    next_flush_zero;
  logic [FPSC_CAUSE_W-1:0] next_cause;
  logic [FPSC_COND_W-1:0]  next_enables;
  logic [FPSC_COND_W-1:0]  next_flags;
  fpsc_rm_t                next_rounding_select;
  logic                    next_trap;
  logic                    op_traps;
  logic [FPSC_DATA_W-1:0]  read_view;
  logic                    flags_seen;

  wire logic wr_cs  = ctl_wr_i && (ctl_addr_i == FPSC_ADDR_CTL_STATUS);
  wire logic wr_cc  = ctl_wr_i && (ctl_addr_i == FPSC_ADDR_CC_VIEW);
  wire logic wr_exc = ctl_wr_i && (ctl_addr_i == FPSC_ADDR_EXC_VIEW);

  // ----------------------------------------
  // next field values: write first, arithmetic result on top
  // ----------------------------------------
  always_comb
  begin
    next_fp_condition_codes = fp_condition_codes;
    next_flush_zero         = flush_zero;
    next_cause              = cause;
    next_enables            = enables;
    next_flags              = flags;
    next_rounding_select    = rounding_select;
    if (wr_cs)
    begin
      next_fp_condition_codes = {ctl_wdata_i[FPSC_CS_CC_HI_MSB:FPSC_CS_CC_HI_LSB], ctl_wdata_i[FPSC_CS_CC0]};
      next_flush_zero         = ctl_wdata_i[FPSC_CS_FLUSH];
      next_cause              = ctl_wdata_i[FPSC_CAUSE_MSB:FPSC_CAUSE_LSB];
      next_enables            = ctl_wdata_i[FPSC_ENABLE_MSB:FPSC_ENABLE_LSB];
      next_flags              = ctl_wdata_i[FPSC_FLAG_MSB:FPSC_FLAG_LSB];
      next_rounding_select    = fpsc_rm_t'(ctl_wdata_i[FPSC_RM_MSB:FPSC_RM_LSB]);
    end
    if (wr_cc)
    begin
      next_fp_condition_codes = ctl_wdata_i[FPSC_CC_W-1:0];
    end
    if (wr_exc)
    begin
      next_cause = ctl_wdata_i[FPSC_CAUSE_MSB:FPSC_CAUSE_LSB];
      next_flags = ctl_wdata_i[FPSC_FLAG_MSB:FPSC_FLAG_LSB];
    end
    // trap test uses the enables in force for this operation
    op_traps = op_cond_i[FPSC_BIT_UNIMPL] | (|(op_cond_i[FPSC_COND_W-1:0] & next_enables));
    if (op_done_i)
    begin
      next_cause = op_cond_i;
      if (!op_traps)
      begin
        next_flags = next_flags | op_cond_i[FPSC_COND_W-1:0];
      end
      // a trapping operation leaves the flags alone
    end
    next_trap = next_cause[FPSC_BIT_UNIMPL]
              | (|(next_cause[FPSC_COND_W-1:0] & next_enables));
  end

  // ----------------------------------------
  // storage with reset
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      fp_condition_codes <= FPSC_CC_RST;
      flush_zero         <= FPSC_FLUSH_RST;
      cause              <= FPSC_CAUSE_RST;
      enables            <= FPSC_ENABLE_RST;
      rounding_select    <= FPSC_RM_RST;
    end
    else
    begin
      fp_condition_codes <= next_fp_condition_codes;
      flush_zero         <= next_flush_zero;
      cause              <= next_cause;
      enables            <= next_enables;
      rounding_select    <= next_rounding_select;
    end
  end

  // flags keep their value through reset
  always_ff @(posedge ref_clk_i)
  begin
    flags <= next_flags;
    if (wr_cs || wr_exc)
      flags_seen <= 1'b1;
  end

  // ----------------------------------------
  // exception request
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      fp_trap_o <= 1'b0;
    end
    else
    begin
      fp_trap_o <= next_trap;
    end
  end

  // ----------------------------------------
  // state outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rounding_select_o    <= FPSC_RM_RST;
      flush_zero_o         <= FPSC_FLUSH_RST;
      fp_condition_codes_o <= FPSC_CC_RST;
    end
    else
    begin
      rounding_select_o    <= next_rounding_select;
      flush_zero_o         <= next_flush_zero;
      fp_condition_codes_o <= next_fp_condition_codes;
    end
  end

  // ----------------------------------------
  // read views
  // ----------------------------------------
  always_comb
  begin
    read_view = '0;
    case (ctl_addr_i)
      FPSC_ADDR_CTL_STATUS:
      begin
        read_view[FPSC_CS_CC_HI_MSB:FPSC_CS_CC_HI_LSB] = fp_condition_codes[FPSC_CC_W-1:1];
        read_view[FPSC_CS_FLUSH]                       = flush_zero;
        read_view[FPSC_CS_CC0]                         = fp_condition_codes[0];
        read_view[FPSC_CAUSE_MSB:FPSC_CAUSE_LSB]       = cause;
        read_view[FPSC_ENABLE_MSB:FPSC_ENABLE_LSB]     = enables;
        read_view[FPSC_FLAG_MSB:FPSC_FLAG_LSB]         = flags;
        read_view[FPSC_RM_MSB:FPSC_RM_LSB]             = rounding_select;
      end
      FPSC_ADDR_CC_VIEW:
      begin
        read_view[FPSC_CC_W-1:0] = fp_condition_codes;
      end
      FPSC_ADDR_EXC_VIEW:
      begin
        read_view[FPSC_CAUSE_MSB:FPSC_CAUSE_LSB] = cause;
        read_view[FPSC_FLAG_MSB:FPSC_FLAG_LSB]   = flags;
      end
      default: read_view = '0;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctl_rdata_o  <= '0;
      ctl_rvalid_o <= 1'b0;
    end
    else
    begin
      ctl_rvalid_o <= ctl_rd_i;
      if (ctl_rd_i)
      begin
        ctl_rdata_o <= read_view;
      end
    end
  end

  // ----------------------------------------
  // rounding decision
  // ----------------------------------------
  fpsc_round_if rnd_bus ();

  assign rnd_bus.mode   = rnd_fixed_i ? fpsc_rm_t'(rnd_fixed_mode_i) : rounding_select;
  assign rnd_bus.sign   = rnd_sign_i;
  assign rnd_bus.lsb    = rnd_lsb_i;
  assign rnd_bus.guard  = rnd_guard_i;
  assign rnd_bus.sticky = rnd_sticky_i;

  fpsc_round_decide u_round_decide
  (
    .rnd (rnd_bus.decider)
  );

  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rnd_incr_o    <= 1'b0;
      rnd_inexact_o <= 1'b0;
      rnd_valid_o   <= 1'b0;
    end
    else
    begin
      rnd_valid_o   <= rnd_req_i;
      rnd_incr_o    <= rnd_req_i & rnd_bus.round_up;
      rnd_inexact_o <= rnd_req_i & rnd_bus.inexact;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_cc_write;
    wr_cc;
  endsequence

  sequence s_cs_read_next;
    (ctl_rd_i && ctl_addr_i == FPSC_ADDR_CTL_STATUS) ##1 ctl_rvalid_o;
  endsequence

  property p_trap_follows_cause;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ##1 (fp_trap_o == (cause[FPSC_BIT_UNIMPL] | (|(cause[FPSC_COND_W-1:0] & enables))));
  endproperty
  a_trap_follows_cause: assert property (p_trap_follows_cause) else $error("trap does not match cause and enables");

  property p_unimpl_traps;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (op_done_i && op_cond_i[FPSC_BIT_UNIMPL]) |=> fp_trap_o;
  endproperty
  a_unimpl_traps: assert property (p_unimpl_traps) else $error("unimplemented operation did not trap");

  property p_flag_accumulate;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (op_done_i && !ctl_wr_i && !op_traps) |=> (flags == ($past(flags) | $past(op_cond_i[FPSC_COND_W-1:0])));
  endproperty
  a_flag_accumulate: assert property (p_flag_accumulate) else $error("untrapped flags not accumulated");

  property p_flag_hold_on_trap;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (op_done_i && !ctl_wr_i && op_traps) |=> $stable(flags);
  endproperty
  a_flag_hold_on_trap: assert property (p_flag_hold_on_trap) else $error("trapping operation changed flags");

  property p_flag_never_falls;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (flags_seen && !ctl_wr_i) |=> ((flags & $past(flags)) == $past(flags));
  endproperty
  a_flag_never_falls: assert property (p_flag_never_falls) else $error("hardware cleared a flag");

  property p_cause_rewrite;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    op_done_i |=> (cause == $past(op_cond_i));
  endproperty
  a_cause_rewrite: assert property (p_cause_rewrite) else $error("cause not rewritten by operation");

  property p_cc_alias;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    s_cc_write ##1 (!ctl_wr_i) ##1 s_cs_read_next |->
      ({ctl_rdata_o[FPSC_CS_CC_HI_MSB:FPSC_CS_CC_HI_LSB], ctl_rdata_o[FPSC_CS_CC0]}
       == $past(ctl_wdata_i[FPSC_CC_W-1:0], 3));
  endproperty
  a_cc_alias: assert property (p_cc_alias) else $error("condition-code write not seen in main view");

  property p_reserved_zero;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (ctl_rd_i && ctl_addr_i == FPSC_ADDR_EXC_VIEW) |=>
      (ctl_rdata_o[31:18] == 14'h0 && ctl_rdata_o[11:7] == 5'h0 && ctl_rdata_o[1:0] == 2'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits of exception view not zero");

  property p_nearest_tie_even;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (rnd_req_i && rnd_bus.mode == fpsc_round_nearest_even && rnd_guard_i && !rnd_sticky_i)
      |=> (rnd_incr_o == $past(rnd_lsb_i));
  endproperty
  a_nearest_tie_even: assert property (p_nearest_tie_even) else $error("tie not rounded to even");

  property p_toward_zero;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    (rnd_req_i && !rnd_fixed_i && rounding_select == fpsc_round_toward_zero) |=> (!rnd_incr_o && rnd_valid_o);
  endproperty
  a_toward_zero: assert property (p_toward_zero) else $error("round toward zero incremented");

endmodule : fpsc_status_control_regs

// ---- tb_fpu_status_control_regs.sv ----
// file: self-checking testbench of the fp control/status register bank
`timescale 1ns/1ps
module tb_fpu_status_control_regs;
  import fpsc_pkg::*;
  logic        ref_clk_i;
  logic        reset_n_i;
  logic        ctl_wr;
  logic        ctl_rd;
  logic [4:0]  ctl_addr;
  logic [31:0] ctl_wdata;
  logic [31:0] ctl_rdata_o;
  logic        ctl_rvalid_o;
  logic        op_done;
  logic [5:0]  op_cond;
  logic        rnd_req;
  logic        rnd_fixed;
  logic [1:0]  rnd_fixed_mode;
  logic [3:0]  rnd_bits;
  logic        rnd_incr_o;
  logic        rnd_inexact_o;
  logic        rnd_valid_o;
  logic [1:0]  rounding_select_o;
  logic        flush_zero_o;
  logic [7:0]  fp_condition_codes_o;
  logic        fp_trap_o;
  int          n_mismatch;
  int          cmp_count;

  // ----------------------------------------
  // clock, instances
  // ----------------------------------------
  initial
  begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  fpsc_core_model i_core
  (
    .ref_clk_i        (ref_clk_i),
    .op_done_o        (op_done),
    .op_cond_o        (op_cond),
    .rnd_req_o        (rnd_req),
    .rnd_fixed_o      (rnd_fixed),
    .rnd_fixed_mode_o (rnd_fixed_mode),
    .rnd_bits_o       (rnd_bits)
  );

  fpsc_status_control_regs i_dut
  (
    .ref_clk_i            (ref_clk_i),
    .reset_n_i            (reset_n_i),
    .ctl_wr_i             (ctl_wr),
    .ctl_rd_i             (ctl_rd),
    .ctl_addr_i           (ctl_addr),
    .ctl_wdata_i          (ctl_wdata),
    .ctl_rdata_o          (ctl_rdata_o),
    .ctl_rvalid_o         (ctl_rvalid_o),
    .op_done_i            (op_done),
    .op_cond_i            (op_cond),
    .rnd_req_i            (rnd_req),
    .rnd_fixed_i          (rnd_fixed),
    .rnd_fixed_mode_i     (rnd_fixed_mode),
    .rnd_sign_i           (rnd_bits[3]),
    .rnd_lsb_i            (rnd_bits[2]),
    .rnd_guard_i          (rnd_bits[1]),
    .rnd_sticky_i         (rnd_bits[0]),
    .rnd_incr_o           (rnd_incr_o),
    .rnd_inexact_o        (rnd_inexact_o),
    .rnd_valid_o          (rnd_valid_o),
    .rounding_select_o    (rounding_select_o),
    .flush_zero_o         (flush_zero_o),
    .fp_condition_codes_o (fp_condition_codes_o),
    .fp_trap_o            (fp_trap_o)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic do_reset();
    @(posedge ref_clk_i);
    reset_n_i <= 1'b0;
    repeat (16) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
  endtask : do_reset

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    ctl_wr    <= 1'b1;
    ctl_addr  <= a;
    ctl_wdata <= d;
    @(posedge ref_clk_i);
    ctl_wr    <= 1'b0;
    ctl_wdata <= ~d;
  endtask : wr

  // read one view and compare, bounded wait for the answer
  task automatic rc(input logic [4:0] a, input logic [31:0] exp);
    int i;
    @(posedge ref_clk_i);
    ctl_rd   <= 1'b1;
    ctl_addr <= a;
    @(posedge ref_clk_i);
    ctl_rd <= 1'b0;
    for (i = 0; i < 4; i++)
    begin
      #1;
      if (ctl_rvalid_o === 1'b1)
        break;
      @(posedge ref_clk_i);
    end
    if (i == 4)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t read answer missing", $time);
      tally_and_finish();
    end
    else
      chk(ctl_rdata_o, exp);
  endtask : rc

  task automatic settle();
    @(posedge ref_clk_i);
    #1;
  endtask : settle

  task automatic op_chk(input logic [5:0] c, input logic [31:0] e, input logic t);
    i_core.do_op(c);
    settle();
    chk({31'h0, fp_trap_o}, {31'h0, t});
    rc(FPSC_ADDR_EXC_VIEW, e);
  endtask : op_chk

  function automatic logic exp_inc(input logic [1:0] m, input logic [3:0] b);
    case (m)
      2'h0: return b[1] & (b[0] | b[2]);
      2'h1: return 1'b0;
      2'h2: return ~b[3] & (b[1] | b[0]);
      default: return b[3] & (b[1] | b[0]);
    endcase
  endfunction : exp_inc

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    n_mismatch = 0;
    cmp_count  = 0;
    reset_n_i  = 1'b0;
    ctl_wr     = 1'b0;
    ctl_rd     = 1'b0;
    ctl_addr   = 5'h00;
    ctl_wdata  = 32'h0;
    do_reset();
    wr(FPSC_ADDR_CTL_STATUS, 32'h0);
    wr(FPSC_ADDR_CC_VIEW, 32'hFFFFFFA5);
    settle();
    chk({24'h0, fp_condition_codes_o}, 32'h000000A5);
    rc(FPSC_ADDR_CC_VIEW, 32'h000000A5);
    rc(FPSC_ADDR_CTL_STATUS, 32'hA4800000);
    wr(FPSC_ADDR_EXC_VIEW, 32'hFFFFFFFF);
    rc(FPSC_ADDR_EXC_VIEW, 32'h0003F07C);
    rc(FPSC_ADDR_CTL_STATUS, 32'hA483F07C);
    chk({31'h0, fp_trap_o}, 32'h1);
    wr(FPSC_ADDR_CTL_STATUS, 32'h01000F83);
    rc(FPSC_ADDR_EXC_VIEW, 32'h0);
    rc(FPSC_ADDR_CC_VIEW, 32'h0);
    chk({29'h0, flush_zero_o, rounding_select_o}, 32'h7);
    wr(5'h1C, 32'hFFFFFFFF);
    rc(5'h1C, 32'h0);
    rc(FPSC_ADDR_CTL_STATUS, 32'h01000F83);
    wr(FPSC_ADDR_CC_VIEW, 32'h0000005A);
    rc(FPSC_ADDR_CTL_STATUS, 32'h5B000F83);
    $display("test views done");
    for (int b = 0; b < 5; b++)
    begin
      wr(FPSC_ADDR_CTL_STATUS, (32'h1 << (12 + b)) | (32'h1 << (7 + b)));
      settle();
      chk({31'h0, fp_trap_o}, 32'h1);
      wr(FPSC_ADDR_CTL_STATUS, (32'h1 << (12 + b)) | (32'h1 << (7 + (b + 1) % 5)));
      settle();
      chk({31'h0, fp_trap_o}, 32'h0);
    end
    $display("test trap by write done");
    wr(FPSC_ADDR_CTL_STATUS, 32'h0);
    op_chk(6'h01, 32'h00001004, 1'b0);
    op_chk(6'h06, 32'h0000601C, 1'b0);
    op_chk(6'h00, 32'h0000001C, 1'b0);
    op_chk(6'h20, 32'h0002001C, 1'b1);
    wr(FPSC_ADDR_CTL_STATUS, 32'h00000800);
    op_chk(6'h11, 32'h00011000, 1'b1);
    op_chk(6'h01, 32'h00001004, 1'b0);
    $display("test arithmetic done");
    for (int m = 0; m < 4; m++)
    begin
      wr(FPSC_ADDR_CTL_STATUS, {30'h0, m[1:0]});
      settle();
      chk({30'h0, rounding_select_o}, m);
      for (int k = 0; k < 32; k++)
      begin
        i_core.do_round(k[4], ~m[1:0], k[3:0]);
        #1;
        chk({29'h0, rnd_valid_o, rnd_incr_o, rnd_inexact_o},
            {29'h0, 1'b1, exp_inc(k[4] ? ~m[1:0] : m[1:0], k[3:0]), k[1] | k[0]});
      end
    end
    $display("test rounding done");
    wr(FPSC_ADDR_EXC_VIEW, 32'h0000007C);
    do_reset();
    rc(FPSC_ADDR_EXC_VIEW, 32'h0000007C);
    rc(FPSC_ADDR_CTL_STATUS, 32'h0000007C);
    $display("test reset keeps flags done");
    tally_and_finish();
  end
endmodule : tb_fpu_status_control_regs
